// ==== i2c_master_sequencer.sv ====
// Purpose: master-only two-wire serial sequencer behind an AHB-Lite slave
// Assumes: single master on the wire, 32-bit word accesses only
// Notes: bus answers with zero wait states; SDA/SCL are open drain
// Notes on behaviour
// R1 - slave ack after byte sets peer_ok
// R2 - write nack sets refusal, clears peer_ok
// R3 - software ends refused transfer: end, purge
// R4 - stop then clears end_request and refusal
// R5 - transmit event after first data bit
// R6 - software requests end or restart during last
// R7 - no refusal when end/begin already pending
// R8 - stop or restart, then clear request bit
// R9 - software loads address with read bit one
// R10 - software sets begin_request to start transfer
// R11 - refuse_last_request sends nack after byte
// R12 - address bits 3,2,1 report 1D,1E,1F
// R13 - readback_select picks reload or live counter
// R14 - readback_select register: bit0 read/write, rest zero
// R15 - master only, single master, no slave mode
// R16 - serial rate never above 400 kbit/s
// R17 - purge discards pending byte, self-clears
module i2c_master_sequencer
  import i2c_seq_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic IRQ_OUT,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_OUT
);
  // ==========================================================
  // elaboration check
  // ==========================================================
  if (QTR_CYC < 2) begin : g_bad_clk
    $error("system clock too slow for the serial rate");
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic sda_m_q, sda_s_q; // sda metastable / stable stage
  logic scl_m_q, scl_s_q; // scl metastable / stable stage
  // two flops each; only the second stage feeds logic
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      {sda_m_q, sda_s_q, scl_m_q, scl_s_q} <= 4'hF;
    end else begin
      {sda_m_q, sda_s_q} <= {SDA_IN, sda_m_q};
      {scl_m_q, scl_s_q} <= {SCL_IN, scl_m_q};
    end
  end

  // ==========================================================
  // AHB-Lite slave
  // ==========================================================
  logic dp_wr_q; // write data phase pending
  logic [11:0] wa_q; // index of the write in data phase
  logic [7:0] hrdata_q; // read data, loaded in address phase
  wire ap_valid = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire [11:0] a_idx = HADDR_IN[13:2];
  wire a_map = (HADDR_IN[31:14] == 18'h0) & (HADDR_IN[1:0] == 2'h0);
  wire ap_rd = ap_valid & ~HWRITE_IN;

  // true when the data phase writes the given register
  function automatic logic wr_hit(input logic [11:0] idx);
    return dp_wr_q && (wa_q == idx);
  endfunction

  // ==========================================================
  // registers
  // ==========================================================
  logic begin_q, end_q, purge_q, txie_q, nak_q, ten_q; // control
  logic [2:0] ev_q; // sticky events
  logic [2:0] mask_q; // interrupt mask
  logic peer_q; // peer_ok_flag
  logic readback_select_q; // readback_select
  logic [7:0] bhi_q, blo_q; // baud reload bytes
  logic [7:0] tx_q, rx_q; // transmit holding / received byte
  logic full_q; // tx holding byte valid
  logic irq_q; // registered interrupt
  logic [15:0] cnt_q; // live baud counter
  eng_t st_q; // engine state
  logic [1:0] ph_q; // quarter phase within a bit
  logic [2:0] bit_q; // bit index, msb first
  logic [7:0] sh_q; // shift register
  logic rd_mode_q; // read transaction
  logic [1:0] byte_no_q; // byte count, saturating
  logic nak_sent_q; // nack was sent on the last rx byte
  logic ackbit_q; // sampled ack slot level
  logic sda_low_q, scl_low_q; // pin drive-low requests

  // ==========================================================
  // baud generator
  // ==========================================================
  wire [15:0] reload = {bhi_q, blo_q};
  // clamping keeps the bit rate inside the supported range
  wire [15:0] eff = (reload < BAUD_MIN) ? BAUD_MIN : reload; // R16
  wire parked = (st_q == ST_IDLE) | (st_q == ST_WAIT);
  // a slave holding SCL low stretches the low phase
  wire hold = ~scl_low_q & ~scl_s_q & ~parked;
  wire tick = (cnt_q == 16'h0) & ~hold & ~parked;
  wire end_ph = tick & (ph_q == 2'h3);

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) cnt_q <= {BAUD_HI_RST, BAUD_LO_RST};
    else if (parked | tick) cnt_q <= eff;
    else if (!hold) cnt_q <= cnt_q - 16'h1;
  end

  // ==========================================================
  // engine decisions
  // ==========================================================
  wire addr_byte = ten_q ? (byte_no_q == 2'h1) : (byte_no_q == 2'h0);
  wire data_byte = ~addr_byte & (byte_no_q != 2'h0);
  wire byte_tx = (byte_no_q == 2'h0) | ~rd_mode_q | addr_byte;
  wire ending = end_q | begin_q;
  wire ack_end = (st_q == ST_ACK) & end_ph;
  wire peer_set = ack_end & byte_tx & ~ackbit_q; // R1
  wire refuse_ev = ack_end & byte_tx & ackbit_q & ~ending; // R2 R7
  wire rx_done = ack_end & ~byte_tx;
  wire tx_ev = (st_q == ST_BIT) & end_ph & (bit_q == 3'h7)
             & byte_tx & data_byte & txie_q; // R5
  wire ref_now = ev_q[EV_REF] | refuse_ev;
  wire dec = ack_end | (st_q == ST_WAIT);
  wire nxt_stop = dec & end_q; // R8
  wire nxt_start = dec & ~end_q & begin_q; // R8
  wire nxt_rx = dec & ~ending & rd_mode_q & ~nak_sent_q & ~ref_now;
  wire nxt_tx = dec & ~ending & ~rd_mode_q & full_q & ~ref_now;
  wire start_end = (st_q == ST_START) & end_ph;
  wire stop_end = (st_q == ST_STOP) & end_ph;
  wire load = start_end | nxt_tx;

  // ==========================================================
  // engine state machine
  // ==========================================================
  // actions happen at the tick that closes the current quarter
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      bit_q <= 3'h7;
      sh_q <= 8'h00;
      rd_mode_q <= 1'b0;
      byte_no_q <= 2'h0;
      nak_sent_q <= 1'b0;
      ackbit_q <= 1'b1;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
    end else begin
      if (tick) ph_q <= ph_q + 2'h1;
      unique case (st_q)
        ST_IDLE: begin // bus free, both lines released
          ph_q <= 2'h0;
          if (begin_q) st_q <= ST_START;
        end
        ST_START: begin // also serves as repeated start
          if (tick && ph_q == 2'h0) begin
            scl_low_q <= 1'b1;
            sda_low_q <= 1'b0;
          end
          if (tick && ph_q == 2'h1) scl_low_q <= 1'b0;
          if (tick && ph_q == 2'h2) sda_low_q <= 1'b1;
          if (start_end) begin
            scl_low_q <= 1'b1;
            sh_q <= tx_q;
            rd_mode_q <= tx_q[0];
            byte_no_q <= 2'h0;
            nak_sent_q <= 1'b0;
            bit_q <= 3'h7;
            st_q <= ST_BIT;
          end
        end
        ST_BIT: begin // one bit, out and in at once
          if (tick && ph_q == 2'h0) sda_low_q <= byte_tx & ~sh_q[7];
          if (tick && ph_q == 2'h1) scl_low_q <= 1'b0;
          if (tick && ph_q == 2'h2) sh_q <= {sh_q[6:0], sda_s_q};
          if (end_ph) begin
            scl_low_q <= 1'b1;
            bit_q <= bit_q - 3'h1;
            if (bit_q == 3'h0) st_q <= ST_ACK;
          end
        end
        ST_ACK: begin // acknowledge slot
          if (tick && ph_q == 2'h0) begin
            sda_low_q <= ~byte_tx & ~nak_q; // R11
            nak_sent_q <= ~byte_tx & nak_q; // R11
          end
          if (tick && ph_q == 2'h1) scl_low_q <= 1'b0;
          if (tick && ph_q == 2'h2) ackbit_q <= sda_s_q;
          if (end_ph) begin
            scl_low_q <= 1'b1;
            if (byte_no_q != 2'h3) byte_no_q <= byte_no_q + 2'h1;
          end
        end
        ST_WAIT: ph_q <= 2'h0; // scl held low until software acts
        ST_STOP: begin
          if (tick && ph_q == 2'h0) sda_low_q <= 1'b1;
          if (tick && ph_q == 2'h1) scl_low_q <= 1'b0;
          if (tick && ph_q == 2'h2) sda_low_q <= 1'b0; // R4
          if (stop_end) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
      // next step after a byte, or while parked
      if (nxt_stop) st_q <= ST_STOP; // R4 R8
      else if (nxt_start) st_q <= ST_START; // R8
      else if (nxt_rx | nxt_tx) begin
        st_q <= ST_BIT;
        bit_q <= 3'h7;
        if (nxt_tx) sh_q <= tx_q;
      end else if (ack_end) st_q <= ST_WAIT;
    end
  end

  // ==========================================================
  // control and status registers
  // ==========================================================
  wire wr_ctl = wr_hit(IDX_CTRL);
  wire wr_data = wr_hit(IDX_DATA);
  wire [2:0] ev_set = {rx_done, refuse_ev, tx_ev};
  wire [2:0] ev_w1c = wr_hit(IDX_STATUS) ? HWDATA_IN[2:0] : 3'h0;
  // hardware clears refusal when its stop completes
  wire [2:0] ev_clr = ev_w1c | {1'b0, stop_end, 1'b0}; // R4

  // request bits: a software write wins over a hardware clear
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      {ten_q, nak_q, txie_q, purge_q, end_q, begin_q} <= 6'h00;
    end else if (wr_ctl) begin
      {ten_q, nak_q, txie_q, purge_q, end_q, begin_q} <= HWDATA_IN[5:0];
    end else begin
      begin_q <= begin_q & ~start_end; // R8
      end_q <= end_q & ~stop_end; // R4 R8
      purge_q <= 1'b0; // R17
    end
  end

  // events: a set in the clearing cycle is kept
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ev_q <= 3'h0;
      irq_q <= 1'b0;
      peer_q <= 1'b0;
    end else begin
      ev_q <= ev_set | (ev_q & ~ev_clr); // R2
      irq_q <= |(ev_q & mask_q);
      if (peer_set) peer_q <= 1'b1; // R1
      else if (refuse_ev) peer_q <= 1'b0; // R2
    end
  end

  // holding byte: purge discards it, a new write refills it
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_q <= 8'h00;
      full_q <= 1'b0;
      rx_q <= 8'h00;
    end else begin
      if (wr_data) tx_q <= HWDATA_IN[7:0];
      full_q <= wr_data | (full_q & ~load & ~purge_q); // R17
      if (rx_done) rx_q <= sh_q;
    end
  end

  // plain configuration registers
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bhi_q <= BAUD_HI_RST;
      blo_q <= BAUD_LO_RST;
      mask_q <= 3'h0;
      readback_select_q <= 1'b0; // R14
    end else begin
      if (wr_hit(IDX_BAUD_HI)) bhi_q <= HWDATA_IN[7:0];
      if (wr_hit(IDX_BAUD_LO)) blo_q <= HWDATA_IN[7:0];
      if (wr_hit(IDX_MASK)) mask_q <= HWDATA_IN[2:0];
      if (wr_hit(IDX_READBACK_SELECT)) readback_select_q <= HWDATA_IN[READBACK_SELECT_SEL]; // R14
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  wire [4:0] addr_code = (bit_q == 3'h0) ? CODE_ADDR_B0
                       : 5'(CODE_ADDR_TOP - {3'h0, bit_q}); // R12
  wire [4:0] code = (st_q == ST_BIT) ?
                      (addr_byte ? addr_code : {CODE_DATA, bit_q})
                  : (st_q == ST_ACK) ? CODE_ACK
                  : (st_q == ST_START) ? CODE_START
                  : (st_q == ST_STOP) ? CODE_STOP
                  : (st_q == ST_WAIT) ? CODE_WAIT : CODE_IDLE;
  wire [7:0] sts_byte = {2'h0, full_q, ~parked, peer_q, ev_q};
  wire [7:0] ctl_byte = {2'h0, ten_q, nak_q, txie_q, purge_q, end_q,
                         begin_q};
  // live counter or reload, chosen by readback_select
  wire [15:0] baud_rd = readback_select_q ? cnt_q : reload; // R13
  wire [7:0] rd_byte = ~a_map ? 8'h00
                     : (a_idx == IDX_DATA) ? rx_q
                     : (a_idx == IDX_STATUS) ? sts_byte
                     : (a_idx == IDX_CTRL) ? ctl_byte
                     : (a_idx == IDX_BAUD_HI) ? baud_rd[15:8]
                     : (a_idx == IDX_BAUD_LO) ? baud_rd[7:0]
                     : (a_idx == IDX_SHIFT) ? {3'h0, code}
                     : (a_idx == IDX_READBACK_SELECT) ? {7'h00, readback_select_q} // R14
                     : (a_idx == IDX_MASK) ? {5'h00, mask_q} : 8'h00;

  // read data is sampled in the address phase, so a read right
  // after a write to the same register returns the old value
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dp_wr_q <= 1'b0;
      wa_q <= 12'h000;
      hrdata_q <= 8'h00;
    end else begin
      dp_wr_q <= ap_valid & HWRITE_IN & a_map;
      wa_q <= a_idx;
      if (ap_rd) hrdata_q <= rd_byte;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign HRDATA_OUT = {24'h000000, hrdata_q};
  assign HREADYOUT_OUT = 1'b1; // zero wait states
  assign HRESP_OUT = 1'b0; // always OKAY
  assign IRQ_OUT = irq_q;
  assign SDA_OUT = 1'b0; // open drain: only ever pulls low
  assign SDA_OE_OUT = sda_low_q;
  assign SCL_OUT = 1'b0;
  assign SCL_OE_OUT = scl_low_q; // R15

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_stop_edge;
    st_q == ST_STOP && tick && ph_q == 2'h2;
  endsequence
  sequence s_released;
    !SDA_OE_OUT && !SCL_OE_OUT;
  endsequence
  a_peer_ack: assert property (peer_set |=> peer_q) // R1
    else $error("ack did not set peer flag");
  a_refuse_nack: assert property (refuse_ev |=> ev_q[EV_REF] && !peer_q) // R2
    else $error("nack did not raise refusal");
  a_stop_release: assert property (s_stop_edge |=> s_released) // R4
    else $error("stop did not release the lines");
  a_stop_clears: assert property (stop_end && !wr_ctl
    |=> !end_q && st_q == ST_IDLE) // R8
    else $error("stop did not clear end request");
  a_tx_first: assert property (tx_ev |=> ev_q[EV_TX]) // R5
    else $error("transmit event missed");
  a_no_refuse_end: assert property (ack_end && ending && !ev_q[EV_REF]
    |=> !ev_q[EV_REF]) // R7
    else $error("refusal raised while ending");
  a_nak_last: assert property (st_q == ST_ACK && tick && ph_q == 2'h0
    && !byte_tx && nak_q |=> !SDA_OE_OUT) // R11
    else $error("last read byte acknowledged");
  a_addr_code: assert property (st_q == ST_BIT && addr_byte
    && bit_q == 3'h3 |-> code == 5'h1D) // R12
    else $error("wrong shift code for address bit 3");
  a_baud_read: assert property (ap_rd && a_map && a_idx == IDX_BAUD_LO
    && !readback_select_q |=> HRDATA_OUT == {24'h0, $past(blo_q)}) // R13
    else $error("baud low read not reload value");
  a_readback_select_bits: assert property (ap_rd && a_map && a_idx == IDX_READBACK_SELECT
    |=> HRDATA_OUT[31:1] == 31'h0) // R14
    else $error("readback_select reserved bits not zero");
  a_master_only: assert property (SCL_OE_OUT |-> st_q != ST_IDLE) // R15
    else $error("scl driven while idle");
  a_tick_space: assert property (tick |=> !tick [*6]) // R16
    else $error("quarter period too short");
  a_purge: assert property (purge_q && !wr_data && !wr_ctl
    |=> !purge_q && !full_q) // R17
    else $error("purge did not discard");
endmodule // i2c_master_sequencer

// ==== i2c_seq_pkg.sv ====
// Purpose: shared constants and types for the two-wire master sequencer
// Assumes: 10 MHz system clock, 32-bit AHB-Lite register access
// Notes: register offsets are word indices; byte address is index * 4
package i2c_seq_pkg;
  // ==========================================================
  // timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 10_000_000; // system clock rate
  localparam int unsigned MAX_BIT_HZ = 400_000; // fastest serial rate
  // quarter bit period, rounded up so the rate never exceeds the max
  localparam int unsigned QTR_CYC =
    (CLK_HZ + 4 * MAX_BIT_HZ - 1) / (4 * MAX_BIT_HZ);
  localparam logic [15:0] BAUD_MIN = 16'(QTR_CYC - 1); // least reload
  // ==========================================================
  // register indices (byte address = index * 4)
  // ==========================================================
  localparam logic [11:0] IDX_DATA = 12'hF50; // tx write / rx read
  localparam logic [11:0] IDX_STATUS = 12'hF51; // events and state
  localparam logic [11:0] IDX_CTRL = 12'hF52; // request bits
  localparam logic [11:0] IDX_BAUD_HI = 12'hF53; // reload high byte
  localparam logic [11:0] IDX_BAUD_LO = 12'hF54; // reload low byte
  localparam logic [11:0] IDX_SHIFT = 12'hF55; // shift state code
  localparam logic [11:0] IDX_READBACK_SELECT = 12'hF56; // baud_readback_control
  localparam logic [11:0] IDX_MASK = 12'hF57; // interrupt mask
  // ==========================================================
  // fields
  // ==========================================================
  localparam int CTL_BEGIN = 0; // begin_request
  localparam int CTL_END = 1; // end_request
  localparam int CTL_PURGE = 2; // purge_request
  localparam int CTL_TXIE = 3; // transmit_irq_enable
  localparam int CTL_NAK = 4; // refuse_last_request
  localparam int CTL_TEN = 5; // 10-bit addressing
  localparam int EV_TX = 0; // transmit event
  localparam int EV_REF = 1; // refusal_irq_flag
  localparam int EV_RX = 2; // byte received
  localparam int READBACK_SELECT_SEL = 0; // readback_select
  localparam logic [7:0] BAUD_HI_RST = 8'h00; // reload reset, high
  localparam logic [7:0] BAUD_LO_RST = BAUD_MIN[7:0]; // reload reset, low
  // ==========================================================
  // shift state codes
  // ==========================================================
  localparam logic [5:0] CODE_ADDR_TOP = 6'h20; // addr bit b -> top - b
  localparam logic [4:0] CODE_ADDR_B0 = 5'h11; // address bit 0
  localparam logic [4:0] CODE_ACK = 5'h10; // acknowledge slot
  localparam logic [1:0] CODE_DATA = 2'h1; // data bit prefix
  localparam logic [4:0] CODE_IDLE = 5'h00;
  localparam logic [4:0] CODE_START = 5'h01;
  localparam logic [4:0] CODE_STOP = 5'h02;
  localparam logic [4:0] CODE_WAIT = 5'h03;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_WAIT, ST_STOP
  } eng_t;
endpackage

// ==== i2c_slave_model.sv ====
// Purpose: behavioural slave on the two-wire bus, partner of the sequencer
// Assumes: wires are pulled up; this model never stretches the clock
// Notes: acks its own address, acks data only when told to
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A // address this slave answers to
) (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ack_data_in,
  input wire logic [7:0] rd_byte_in,
  output logic sda_oe_out,
  output logic [7:0] got_byte_out,
  output logic m_nack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh; // shift of the incoming bits
  int cnt; // bits seen in the current byte, ack slot is the ninth
  logic first, rd, sel; // address byte, read direction, selected
  initial begin
    sda_oe_out = 1'b0;
    got_byte_out = 8'h00;
    m_nack_out = 1'b0;
    cnt = 0;
    first = 1'b0;
    rd = 1'b0;
    sel = 1'b0;
    sh = 8'h00;
  end
  // ==========================================================
  // start and stop detection
  // ==========================================================
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    cnt = 0;
    first = 1'b1;
    sel = 1'b0;
    m_nack_out = 1'b0;
  end
  // stop: deselect so that sda stays released
  always @(posedge sda_in) if (scl_in === 1'b1) begin
    sel = 1'b0;
    sda_oe_out = 1'b0;
  end
  // ==========================================================
  // sampling while scl is high
  // ==========================================================
  always @(posedge scl_in) begin
    if (cnt < 8) sh = {sh[6:0], sda_in};
    else if (rd && !first) m_nack_out = sda_in;
    cnt = cnt + 1;
  end
  // sda changes only while scl is low, so no false start or stop
  always @(negedge scl_in) begin
    if (cnt == 8) begin
      if (first) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end else if (!rd) got_byte_out = sh;
      sda_oe_out = sel && (first || (!rd && ack_data_in));
    end else if (cnt == 9) begin
      // after a master nack the line is let go for the stop
      sda_oe_out = sel && rd && (first || !m_nack_out) && !rd_byte_in[7];
      cnt = 0;
      first = 1'b0;
    end else if (sel && rd && !first) sda_oe_out = !rd_byte_in[7 - cnt];
  end
endmodule // i2c_slave_model

// ==== testbench.sv ====
// Purpose: self-checking bench for the two-wire master sequencer
// Assumes: the bus answers through hready; wires pulled up to one
// Notes: the master waits on hready and assumes no fixed latency
module testbench
  import i2c_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SLV = 7'h2A; // model address
  typedef struct {
    logic [11:0] idx;
    logic wr;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  logic clk, rst_n, hsel, hwrite, ack_data, hready, hresp, irq;
  logic sda_o, sda_oe, scl_o, scl_oe, s_oe, mnack;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] rd_byte, got, a;
  logic seen [32]; // shift codes observed during the address byte
  int failures, n_compared, cyc, last_rise, min_per;
  wire sda_w = ~(sda_oe | s_oe); // open drain, pulled up
  wire scl_w = ~scl_oe;
  // register table rows: reset values, access kinds, unmapped place
  row_t rows [11] = '{
    '{IDX_STATUS, 1'b0, 8'h00, 8'h00}, '{IDX_CTRL, 1'b0, 8'h00, 8'h00},
    '{IDX_BAUD_HI, 1'b0, 8'h00, BAUD_HI_RST},
    '{IDX_BAUD_LO, 1'b0, 8'h00, BAUD_LO_RST},
    '{IDX_SHIFT, 1'b0, 8'h00, {3'h0, CODE_IDLE}},
    '{IDX_READBACK_SELECT, 1'b0, 8'h00, 8'h00}, '{IDX_READBACK_SELECT, 1'b1, 8'hFF, 8'h01},
    '{IDX_READBACK_SELECT, 1'b1, 8'h00, 8'h00}, '{IDX_MASK, 1'b1, 8'hFF, 8'h07},
    '{IDX_BAUD_LO, 1'b1, 8'h00, 8'h00}, '{12'hF5F, 1'b1, 8'h5A, 8'h00}};
  i2c_master_sequencer DUT (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .IRQ_OUT(irq), .SDA_IN(sda_w), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .SCL_IN(scl_w), .SCL_OUT(scl_o),
    .SCL_OE_OUT(scl_oe));
  i2c_slave_model #(.ADDR(SLV)) slave (.scl_in(scl_w), .sda_in(sda_w),
    .ack_data_in(ack_data), .rd_byte_in(rd_byte), .sda_oe_out(s_oe),
    .got_byte_out(got), .m_nack_out(mnack));
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic check(input logic [31:0] sv, input logic [31:0] ev);
    n_compared++;
    if (sv !== ev) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, sv, ev);
    end
  endtask
  // one single transfer; the leading idle cycle keeps a read off the
  // data phase of a preceding write, which would see the old value
  task automatic xfer(input logic [11:0] idx, input logic wr,
                      input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // bounded wait for one register bit
  task automatic poll(input logic [11:0] idx, input int b, input logic v);
    int n;
    n = 0;
    do begin
      xfer(idx, 1'b0, 8'h00);
      n++;
    end while (rd[b] !== v && n < 3000);
    if (rd[b] !== v) begin
      failures++;
      $display("ERROR t=%0t wait for register bit timed out", $time);
    end
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    check(irq, v);
  endtask
  task automatic print_verdict;
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // clock, bit-rate monitor, watchdog
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // shortest spacing of scl rises, i.e. the fastest bit seen
  always @(posedge scl_w) begin
    if (last_rise > 0 && cyc - last_rise < min_per) min_per = cyc - last_rise;
    last_rise = cyc;
  end
  initial begin
    #8_000_000;
    failures++;
    print_verdict;
  end
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {ack_data, rd_byte, failures, n_compared} = {1'b1, 8'hC3, 64'h0};
    {cyc, last_rise, min_per} = {32'h0, 32'h0, 32'd1000};
    foreach (seen[k]) seen[k] = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({irq, sda_oe, scl_oe, hresp, sda_o, scl_o}, 6'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) xfer(rows[i].idx, 1'b1, rows[i].wd);
      xfer(rows[i].idx, 1'b0, 8'h00);
      check(rd, {24'h0, rows[i].exp});
    end
    // write one byte; slave refuses it but end is already pending
    xfer(IDX_MASK, 1'b1, 8'h01);
    xfer(IDX_DATA, 1'b1, {SLV, 1'b0});
    xfer(IDX_CTRL, 1'b1, 8'h09);
    rd = '0;
    for (int i = 0; i < 400 && rd[4:0] !== CODE_ACK; i++) begin
      xfer(IDX_SHIFT, 1'b0, 8'h00);
      seen[rd[4:0]] = 1'b1;
    end
    check({seen[29], seen[30], seen[31]}, 3'h7);
    poll(IDX_CTRL, CTL_BEGIN, 1'b0);
    poll(IDX_STATUS, 4, 1'b0);
    check(rd[3], 1'b1);
    ack_data <= 1'b0;
    xfer(IDX_DATA, 1'b1, 8'hA5);
    poll(IDX_STATUS, EV_TX, 1'b1);
    xfer(IDX_SHIFT, 1'b0, 8'h00);
    check(rd[4:0], 5'h0E);
    irq_is(1'b1);
    xfer(IDX_CTRL, 1'b1, 8'h02);
    poll(IDX_CTRL, CTL_END, 1'b0);
    check({sda_w, scl_w, got}, {2'h3, 8'hA5});
    xfer(IDX_STATUS, 1'b1, 8'h01);
    xfer(IDX_STATUS, 1'b0, 8'h00);
    check(rd[2:0], 3'h0);
    irq_is(1'b0);
    // refused data byte with nothing pending, then abandoned
    xfer(IDX_MASK, 1'b1, 8'h02);
    xfer(IDX_DATA, 1'b1, {SLV, 1'b0});
    xfer(IDX_CTRL, 1'b1, 8'h09);
    poll(IDX_CTRL, CTL_BEGIN, 1'b0);
    poll(IDX_STATUS, 4, 1'b0);
    xfer(IDX_DATA, 1'b1, 8'h3C);
    poll(IDX_STATUS, EV_REF, 1'b1);
    check(rd[3], 1'b0);
    irq_is(1'b1);
    xfer(IDX_MASK, 1'b1, 8'h00);
    irq_is(1'b0);
    xfer(IDX_MASK, 1'b1, 8'h02);
    irq_is(1'b1);
    // a byte queued while refused stays held until the purge drops it
    xfer(IDX_DATA, 1'b1, 8'h77);
    xfer(IDX_STATUS, 1'b0, 8'h00);
    check(rd[5], 1'b1);
    xfer(IDX_CTRL, 1'b1, 8'h06);
    poll(IDX_CTRL, CTL_END, 1'b0);
    check(rd[7:0], 8'h00);
    xfer(IDX_STATUS, 1'b0, 8'h00);
    check({rd[5], rd[EV_REF]}, 2'h0);
    irq_is(1'b0);
    // single-byte read with nack, live counter readback meanwhile
    xfer(IDX_DATA, 1'b1, {SLV, 1'b1});
    xfer(IDX_CTRL, 1'b1, 8'h11);
    xfer(IDX_READBACK_SELECT, 1'b1, 8'h01);
    xfer(IDX_BAUD_LO, 1'b0, 8'h00);
    a = rd[7:0];
    xfer(IDX_BAUD_LO, 1'b0, 8'h00);
    check(32'(a != rd[7:0]), 1);
    xfer(IDX_READBACK_SELECT, 1'b1, 8'h00);
    poll(IDX_STATUS, EV_RX, 1'b1);
    poll(IDX_STATUS, 4, 1'b0);
    check(mnack, 1'b1);
    // repeated start from the parked state reads the slave once more
    xfer(IDX_STATUS, 1'b1, 8'h04);
    xfer(IDX_CTRL, 1'b1, 8'h11);
    poll(IDX_CTRL, CTL_BEGIN, 1'b0);
    poll(IDX_STATUS, 4, 1'b0);
    check(rd[EV_RX], 1'b1);
    check(mnack, 1'b1);
    xfer(IDX_CTRL, 1'b1, 8'h02);
    poll(IDX_CTRL, CTL_END, 1'b0);
    xfer(IDX_DATA, 1'b0, 8'h00);
    check(rd[7:0], 8'hC3);
    check(32'(min_per >= 25), 1);
    // reset in mid-run returns the diagnostic bit and the pins to rest
    xfer(IDX_READBACK_SELECT, 1'b1, 8'h01);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({irq, sda_oe, scl_oe}, 3'h0);
    xfer(IDX_READBACK_SELECT, 1'b0, 8'h00);
    check(rd, 32'h0);
    print_verdict;
  end
endmodule // testbench
